// *** core/usb_regbank_pkg.sv ***
`default_nettype none
package usb_regbank_pkg;
   localparam int DATA_W = 8;
   localparam int FIFO_DEPTH = 64;
   localparam int CNT_W = 7;
   localparam int MBOX_N = 8;
   localparam int IDX_W = 3;
   localparam int THR_W = 6;
   localparam int ADDR_W = 5;

   localparam logic [ADDR_W-1:0] ADDR_STAT1 = 5'h02;
   localparam logic [ADDR_W-1:0] ADDR_ENB2 = 5'h03;
   localparam logic [ADDR_W-1:0] ADDR_STAT2 = 5'h04;
   localparam logic [ADDR_W-1:0] ADDR_RX_IDX = 5'h08;
   localparam logic [ADDR_W-1:0] ADDR_RX_PORT = 5'h09;
   localparam logic [ADDR_W-1:0] ADDR_TX_IDX = 5'h0c;
   localparam logic [ADDR_W-1:0] ADDR_TX_PORT = 5'h0d;
   localparam logic [ADDR_W-1:0] ADDR_POLL = 5'h0e;
   localparam logic [ADDR_W-1:0] ADDR_RX_DATA = 5'h10;
   localparam logic [ADDR_W-1:0] ADDR_RX_LEVEL = 5'h11;
   localparam logic [ADDR_W-1:0] ADDR_RX_STATE = 5'h12;
   localparam logic [ADDR_W-1:0] ADDR_RX_PKSZ = 5'h13;
   localparam logic [ADDR_W-1:0] ADDR_TX_DATA = 5'h14;
   localparam logic [ADDR_W-1:0] ADDR_TX_LEVEL = 5'h15;
   localparam logic [ADDR_W-1:0] ADDR_TX_STATE = 5'h16;

   localparam int S1_SUSPEND = 7;
   localparam int S1_SOF = 6;
   localparam int S1_EOT = 5;
   localparam int S1_EP4 = 4;
   localparam int S1_EP3 = 3;
   localparam int S1_EP2 = 2;
   localparam int S1_EP1 = 1;
   localparam int S1_UPPER = 0;
   localparam int S2_TX_AE = 1;
   localparam int S2_RX_AF = 0;
   localparam int FS_VALID = 5;
   localparam int FS_FLUSH = 4;
   localparam int FS_OVF = 3;
   localparam int FS_UNF = 2;
   localparam int FS_FULL = 1;
   localparam int FS_EMPTY = 0;

   localparam logic [DATA_W-1:0] BYTE_ZERO = 8'h00;
   localparam logic [DATA_W-1:0] POLL_RST = 8'hff;
   localparam logic [DATA_W-1:0] PKSZ_RST = 8'h08;
   localparam logic [1:0] ENB2_MASK = 2'h3;
   localparam logic [THR_W-1:0] AF_THR_RST = 6'h3c;
   localparam logic [THR_W-1:0] AE_THR_RST = 6'h04;

   typedef struct packed {
      logic cs_n;
      logic rd_n;
      logic wr_n;
      logic dma_acknowledge_n_n;
      logic eot_n;
      logic [ADDR_W-1:0] addr;
      logic [DATA_W-1:0] data;
   } lbus_t;

   typedef struct packed {
      logic suspend_req;
      logic sof;
      logic ep4_sent;
      logic ep3_rcvd;
      logic ep2_read;
      logic ep1_written;
   } sie_event_t;

   typedef struct packed {
      logic wr;
      logic [IDX_W-1:0] idx;
      logic [DATA_W-1:0] data;
   } mbox_wr_t;
endpackage
`default_nettype wire

// *** core/byte_fifo.sv ***
`default_nettype none
module byte_fifo #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 8,
   localparam int PTR_W = $clog2(DEPTH),
   localparam int CNT_W = $clog2(DEPTH + 1)
) (
   input wire logic core_clk_i,
   input wire logic rst_n_i,
   input wire logic flush_i,
   input wire logic in_valid_i,
   input wire logic [WIDTH-1:0] in_data_i,
   output logic in_ready_o,
   output logic out_valid_o,
   output logic [WIDTH-1:0] out_data_o,
   input wire logic out_ready_i,
   output logic [CNT_W-1:0] count_o
);
   logic [WIDTH-1:0] mem_q [DEPTH];
   logic [PTR_W-1:0] wr_ptr_q;
   logic [PTR_W-1:0] rd_ptr_q;
   logic [CNT_W-1:0] count_q;
   logic push;
   logic pop;

   assign in_ready_o = count_q != CNT_W'(DEPTH);
   assign out_valid_o = count_q != '0;
   assign out_data_o = mem_q[rd_ptr_q];
   assign count_o = count_q;
   assign push = in_valid_i & in_ready_o;
   assign pop = out_valid_o & out_ready_i;

   always_ff @(posedge core_clk_i) begin
      if (push) begin
         mem_q[wr_ptr_q] <= in_data_i;
      end
   end

   // Flush beats any push or pop in the same cycle
   always_ff @(posedge core_clk_i) begin
      if (!rst_n_i || flush_i) begin
         wr_ptr_q <= '0;
         rd_ptr_q <= '0;
      end else begin
         if (push) wr_ptr_q <= PTR_W'(wr_ptr_q + 1'b1);
         if (pop) rd_ptr_q <= PTR_W'(rd_ptr_q + 1'b1);
      end
   end

   always_ff @(posedge core_clk_i) begin
      if (!rst_n_i || flush_i) begin
         count_q <= '0;
      end else if (push && !pop) begin
         count_q <= CNT_W'(count_q + 1'b1);
      end else if (pop && !push) begin
         count_q <= CNT_W'(count_q - 1'b1);
      end
   end
endmodule
`default_nettype wire

// *** core/usb_function_local_register_bank.sv ***
`default_nettype none
module usb_function_local_register_bank (
   input wire logic core_clk_i,
   input wire logic rst_n_i,
   input wire usb_regbank_pkg::lbus_t lbus_i,
   output logic [7:0] ldout_o,
   output logic ldout_oe_n_o,
   output logic local_irq_o,
   input wire logic [7:0] interrupt_enable_first_i,
   input wire logic validation_mode_i,
   input wire logic [5:0] almost_full_threshold_i,
   input wire logic [5:0] almost_empty_threshold_i,
   input wire usb_regbank_pkg::sie_event_t sie_event_i,
   input wire usb_regbank_pkg::mbox_wr_t sie_mbox_wr_i,
   output logic [63:0] ep2_mailbox_o,
   output logic [7:0] poll_interval_o,
   output logic [7:0] packet_limit_o,
   input wire logic sie_rx_valid_i,
   input wire logic [7:0] sie_rx_data_i,
   output logic sie_rx_ready_o,
   input wire logic sie_tx_rd_i,
   output logic [7:0] sie_tx_data_o,
   output logic sie_tx_valid_o
);
   localparam int DW = usb_regbank_pkg::DATA_W;
   localparam int CW = usb_regbank_pkg::CNT_W;
   localparam int IW = usb_regbank_pkg::IDX_W;

   function automatic logic hit(input usb_regbank_pkg::lbus_t b,
                                input logic [usb_regbank_pkg::ADDR_W-1:0] a);
      return b.dma_acknowledge_n_n && !b.cs_n && (b.addr == a);
   endfunction

   function automatic logic thr_eq(input logic [CW-1:0] cnt, input logic [5:0] thr);
      return cnt == CW'(thr);
   endfunction

   logic rd_q, wr_q;
   logic rd_take, wr_take, dma;
   logic [DW-1:0] stat1_q, enb2_q, stat2_q;
   logic [DW-1:0] set1, clr1, set2, clr2;
   logic [IW-1:0] rx_idx_q, tx_idx_q;
   logic [DW-1:0] rx_mbox_q [usb_regbank_pkg::MBOX_N];
   logic [usb_regbank_pkg::MBOX_N-1:0][DW-1:0] tx_mbox_q;
   logic [DW-1:0] poll_q, pksz_q, rdata, ldout_q;
   logic ldout_oe_n_q, irq_q;
   logic rx_ovf_q, rx_unf_q, tx_ovf_q, tx_unf_q, tx_valid_q;
   logic rx_port_rd, tx_port_rd, tx_port_wr;
   logic rx_data_rd, tx_data_wr, rx_flush, tx_flush;
   logic rx_in_ready, rx_out_valid, tx_in_ready, tx_out_valid;
   logic [DW-1:0] rx_out_data, tx_out_data;
   logic [CW-1:0] rx_count, tx_count;
   logic rx_push, tx_pop, tx_permit, eot_hit;
   logic rx_ready_q, tx_byte_valid_q;
   logic [DW-1:0] tx_byte_q;

   // Strobes come from logic on this clock; one access per strobe assertion
   assign dma = !lbus_i.dma_acknowledge_n_n;
   assign rd_take = !lbus_i.rd_n && !rd_q && (!lbus_i.cs_n || dma);
   assign wr_take = !lbus_i.wr_n && !wr_q && (!lbus_i.cs_n || dma);

   always_ff @(posedge core_clk_i) begin
      if (!rst_n_i) begin
         rd_q <= 1'b0;
         wr_q <= 1'b0;
      end else begin
         rd_q <= !lbus_i.rd_n;
         wr_q <= !lbus_i.wr_n;
      end
   end

   // DMA acknowledge overrides chip select and the address
   assign rx_port_rd = rd_take && hit(lbus_i, usb_regbank_pkg::ADDR_RX_PORT);
   assign tx_port_rd = rd_take && hit(lbus_i, usb_regbank_pkg::ADDR_TX_PORT);
   assign tx_port_wr = wr_take && hit(lbus_i, usb_regbank_pkg::ADDR_TX_PORT);
   assign rx_data_rd = rd_take && (dma || hit(lbus_i, usb_regbank_pkg::ADDR_RX_DATA));
   assign tx_data_wr = wr_take && (dma || hit(lbus_i, usb_regbank_pkg::ADDR_TX_DATA));
   assign rx_flush = wr_take && hit(lbus_i, usb_regbank_pkg::ADDR_RX_STATE)
                     && lbus_i.data[usb_regbank_pkg::FS_FLUSH];
   assign tx_flush = wr_take && hit(lbus_i, usb_regbank_pkg::ADDR_TX_STATE)
                     && lbus_i.data[usb_regbank_pkg::FS_FLUSH];
   assign eot_hit = !lbus_i.eot_n && dma && (!lbus_i.rd_n || !lbus_i.wr_n);

   assign rx_push = sie_rx_valid_i && rx_in_ready;
   assign tx_permit = !validation_mode_i || tx_valid_q;
   assign tx_pop = sie_tx_rd_i && tx_permit && tx_out_valid;

   byte_fifo #(
      .WIDTH(DW),
      .DEPTH(usb_regbank_pkg::FIFO_DEPTH)
   ) rx_fifo (
      .core_clk_i(core_clk_i),
      .rst_n_i(rst_n_i),
      .flush_i(rx_flush),
      .in_valid_i(sie_rx_valid_i),
      .in_data_i(sie_rx_data_i),
      .in_ready_o(rx_in_ready),
      .out_valid_o(rx_out_valid),
      .out_data_o(rx_out_data),
      .out_ready_i(rx_data_rd),
      .count_o(rx_count)
   );

   byte_fifo #(
      .WIDTH(DW),
      .DEPTH(usb_regbank_pkg::FIFO_DEPTH)
   ) tx_fifo (
      .core_clk_i(core_clk_i),
      .rst_n_i(rst_n_i),
      .flush_i(tx_flush),
      .in_valid_i(tx_data_wr),
      .in_data_i(lbus_i.data),
      .in_ready_o(tx_in_ready),
      .out_valid_o(tx_out_valid),
      .out_data_o(tx_out_data),
      .out_ready_i(tx_pop),
      .count_o(tx_count)
   );

   always_comb begin
      set1 = usb_regbank_pkg::BYTE_ZERO;
      set1[usb_regbank_pkg::S1_SUSPEND] = sie_event_i.suspend_req;
      set1[usb_regbank_pkg::S1_SOF] = sie_event_i.sof;
      set1[usb_regbank_pkg::S1_EOT] = eot_hit;
      set1[usb_regbank_pkg::S1_EP4] = sie_event_i.ep4_sent;
      set1[usb_regbank_pkg::S1_EP3] = sie_event_i.ep3_rcvd;
      set1[usb_regbank_pkg::S1_EP2] = sie_event_i.ep2_read;
      set1[usb_regbank_pkg::S1_EP1] = sie_event_i.ep1_written;
      set2 = usb_regbank_pkg::BYTE_ZERO;
      set2[usb_regbank_pkg::S2_TX_AE] =
         tx_pop && thr_eq(tx_count, almost_empty_threshold_i);
      set2[usb_regbank_pkg::S2_RX_AF] =
         rx_push && thr_eq(rx_count, almost_full_threshold_i);
      clr1 = (wr_take && hit(lbus_i, usb_regbank_pkg::ADDR_STAT1)) ? lbus_i.data
             : usb_regbank_pkg::BYTE_ZERO;
      clr2 = (wr_take && hit(lbus_i, usb_regbank_pkg::ADDR_STAT2)) ? lbus_i.data
             : usb_regbank_pkg::BYTE_ZERO;
   end

   // Set beats a same-cycle clear; zeros written leave bits alone
   always_ff @(posedge core_clk_i) begin
      if (!rst_n_i) begin
         stat1_q <= usb_regbank_pkg::BYTE_ZERO;
         stat2_q <= usb_regbank_pkg::BYTE_ZERO;
      end else begin
         stat1_q <= ((stat1_q & ~clr1) | set1) & ~8'h01;
         stat2_q <= ((stat2_q & ~clr2) | set2) & {6'h00, usb_regbank_pkg::ENB2_MASK};
      end
   end

   always_ff @(posedge core_clk_i) begin
      if (!rst_n_i) begin
         enb2_q <= usb_regbank_pkg::BYTE_ZERO;
         poll_q <= usb_regbank_pkg::POLL_RST;
         pksz_q <= usb_regbank_pkg::PKSZ_RST;
      end else if (wr_take) begin
         if (hit(lbus_i, usb_regbank_pkg::ADDR_ENB2)) begin
            enb2_q <= lbus_i.data & {6'h00, usb_regbank_pkg::ENB2_MASK};
         end
         if (hit(lbus_i, usb_regbank_pkg::ADDR_POLL)) poll_q <= lbus_i.data;
         if (hit(lbus_i, usb_regbank_pkg::ADDR_RX_PKSZ)) pksz_q <= lbus_i.data;
      end
   end

   always_ff @(posedge core_clk_i) begin
      if (!rst_n_i) begin
         rx_idx_q <= '0;
         tx_idx_q <= '0;
      end else begin
         if (wr_take && hit(lbus_i, usb_regbank_pkg::ADDR_RX_IDX)) begin
            rx_idx_q <= lbus_i.data[IW-1:0];
         end else if (rx_port_rd) begin
            rx_idx_q <= rx_idx_q + 3'h1;
         end
         if (wr_take && hit(lbus_i, usb_regbank_pkg::ADDR_TX_IDX)) begin
            tx_idx_q <= lbus_i.data[IW-1:0];
         end else if (tx_port_rd || tx_port_wr) begin
            tx_idx_q <= tx_idx_q + 3'h1;
         end
      end
   end

   // Mailbox bytes: receive side written only from USB, transmit side from local bus
   always_ff @(posedge core_clk_i) begin
      if (!rst_n_i) begin
         for (int i = 0; i < usb_regbank_pkg::MBOX_N; i++) begin
            rx_mbox_q[i] <= usb_regbank_pkg::BYTE_ZERO;
            tx_mbox_q[i] <= usb_regbank_pkg::BYTE_ZERO;
         end
      end else begin
         if (sie_mbox_wr_i.wr) rx_mbox_q[sie_mbox_wr_i.idx] <= sie_mbox_wr_i.data;
         if (tx_port_wr) tx_mbox_q[tx_idx_q] <= lbus_i.data;
      end
   end

   // Error flags: hardware set wins over software clear
   always_ff @(posedge core_clk_i) begin
      if (!rst_n_i) begin
         rx_ovf_q <= 1'b0;
         rx_unf_q <= 1'b0;
         tx_ovf_q <= 1'b0;
         tx_unf_q <= 1'b0;
      end else begin
         if (wr_take && hit(lbus_i, usb_regbank_pkg::ADDR_RX_STATE)) begin
            if (lbus_i.data[usb_regbank_pkg::FS_OVF]) rx_ovf_q <= 1'b0;
            if (lbus_i.data[usb_regbank_pkg::FS_UNF]) rx_unf_q <= 1'b0;
         end
         if (wr_take && hit(lbus_i, usb_regbank_pkg::ADDR_TX_STATE)) begin
            if (lbus_i.data[usb_regbank_pkg::FS_OVF]) tx_ovf_q <= 1'b0;
            if (lbus_i.data[usb_regbank_pkg::FS_UNF]) tx_unf_q <= 1'b0;
         end
         if (sie_rx_valid_i && !rx_in_ready) rx_ovf_q <= 1'b1;
         if (rx_data_rd && !rx_out_valid) rx_unf_q <= 1'b1;
         if (tx_data_wr && !tx_in_ready) tx_ovf_q <= 1'b1;
         if (sie_tx_rd_i && tx_permit && !tx_out_valid) tx_unf_q <= 1'b1;
      end
   end

   // Software write of the valid bit wins over a same-cycle host read
   always_ff @(posedge core_clk_i) begin
      if (!rst_n_i) begin
         tx_valid_q <= 1'b0;
      end else if (wr_take && hit(lbus_i, usb_regbank_pkg::ADDR_TX_STATE)) begin
         tx_valid_q <= lbus_i.data[usb_regbank_pkg::FS_VALID];
      end else if (sie_tx_rd_i && tx_permit) begin
         tx_valid_q <= 1'b0;
      end
   end

   always_comb begin
      rdata = usb_regbank_pkg::BYTE_ZERO;
      if (dma) begin
         rdata = rx_out_data;
      end else begin
         unique case (lbus_i.addr)
            usb_regbank_pkg::ADDR_STAT1: rdata = stat1_q | {7'h00, |stat2_q};
            usb_regbank_pkg::ADDR_ENB2: rdata = enb2_q;
            usb_regbank_pkg::ADDR_STAT2: rdata = stat2_q;
            usb_regbank_pkg::ADDR_RX_IDX: rdata = {5'h00, rx_idx_q};
            usb_regbank_pkg::ADDR_RX_PORT: rdata = rx_mbox_q[rx_idx_q];
            usb_regbank_pkg::ADDR_TX_IDX: rdata = {5'h00, tx_idx_q};
            usb_regbank_pkg::ADDR_TX_PORT: rdata = tx_mbox_q[tx_idx_q];
            usb_regbank_pkg::ADDR_POLL: rdata = poll_q;
            usb_regbank_pkg::ADDR_RX_DATA: rdata = rx_out_valid ? rx_out_data
                                                   : usb_regbank_pkg::BYTE_ZERO;
            usb_regbank_pkg::ADDR_RX_LEVEL: rdata = {1'b0, rx_count};
            usb_regbank_pkg::ADDR_RX_STATE: begin
               rdata[usb_regbank_pkg::FS_OVF] = rx_ovf_q;
               rdata[usb_regbank_pkg::FS_UNF] = rx_unf_q;
               rdata[usb_regbank_pkg::FS_FULL] = !rx_in_ready;
               rdata[usb_regbank_pkg::FS_EMPTY] = !rx_out_valid;
            end
            usb_regbank_pkg::ADDR_RX_PKSZ: rdata = pksz_q;
            usb_regbank_pkg::ADDR_TX_LEVEL: rdata = {1'b0, tx_count};
            usb_regbank_pkg::ADDR_TX_STATE: begin
               rdata[usb_regbank_pkg::FS_VALID] = tx_valid_q;
               rdata[usb_regbank_pkg::FS_OVF] = tx_ovf_q;
               rdata[usb_regbank_pkg::FS_UNF] = tx_unf_q;
               rdata[usb_regbank_pkg::FS_FULL] = !tx_in_ready;
               rdata[usb_regbank_pkg::FS_EMPTY] = !tx_out_valid;
            end
            default: rdata = usb_regbank_pkg::BYTE_ZERO;
         endcase
      end
   end

   // Data is captured at the strobe's first cycle and held while it stays low
   always_ff @(posedge core_clk_i) begin
      if (!rst_n_i) begin
         ldout_q <= usb_regbank_pkg::BYTE_ZERO;
         ldout_oe_n_q <= 1'b1;
      end else begin
         if (rd_take) ldout_q <= rdata;
         ldout_oe_n_q <= !(!lbus_i.rd_n && (!lbus_i.cs_n || dma));
      end
   end

   always_ff @(posedge core_clk_i) begin
      if (!rst_n_i) begin
         irq_q <= 1'b0;
      end else begin
         irq_q <= |(stat1_q & interrupt_enable_first_i & ~8'h01)
                  || |(stat2_q & enb2_q);
      end
   end

   // Ready lags the FIFO by a cycle; a push against a full FIFO is flagged
   always_ff @(posedge core_clk_i) begin
      if (!rst_n_i) begin
         rx_ready_q <= 1'b0;
         tx_byte_valid_q <= 1'b0;
         tx_byte_q <= usb_regbank_pkg::BYTE_ZERO;
      end else begin
         rx_ready_q <= rx_in_ready;
         tx_byte_valid_q <= tx_pop;
         if (tx_pop) tx_byte_q <= tx_out_data;
      end
   end

   assign ldout_o = ldout_q;
   assign ldout_oe_n_o = ldout_oe_n_q;
   assign local_irq_o = irq_q;
   assign ep2_mailbox_o = tx_mbox_q;
   assign poll_interval_o = poll_q;
   assign packet_limit_o = pksz_q;
   assign sie_rx_ready_o = rx_ready_q;
   assign sie_tx_data_o = tx_byte_q;
   assign sie_tx_valid_o = tx_byte_valid_q;

   default clocking cb @(posedge core_clk_i); endclocking
   default disable iff (!rst_n_i);

   property p_no_lost_status;
      1 |=> ((~stat1_q & $past(stat1_q) & ~$past(clr1)) == 8'h00);
   endproperty
   a_no_lost_status: assert property (p_no_lost_status) else $error("status bit lost");

   property p_sof_sets;
      sie_event_i.sof |=> stat1_q[usb_regbank_pkg::S1_SOF];
   endproperty
   a_sof_sets: assert property (p_sof_sets) else $error("sof not latched");

   property p_eot_sets;
      eot_hit |=> stat1_q[usb_regbank_pkg::S1_EOT];
   endproperty
   a_eot_sets: assert property (p_eot_sets) else $error("eot not latched");

   property p_upper_bit;
      rd_take && hit(lbus_i, usb_regbank_pkg::ADDR_STAT1) |=> ldout_q[0] == $past(|stat2_q);
   endproperty
   a_upper_bit: assert property (p_upper_bit) else $error("upper bit wrong");

   property p_almost_empty;
      tx_pop && thr_eq(tx_count, almost_empty_threshold_i)
         |=> stat2_q[usb_regbank_pkg::S2_TX_AE] && tx_count == $past(tx_count) - 7'h01;
   endproperty
   a_almost_empty: assert property (p_almost_empty) else $error("almost empty missed");

   property p_almost_full;
      rx_push && !rx_data_rd && thr_eq(rx_count, almost_full_threshold_i)
         |=> stat2_q[usb_regbank_pkg::S2_RX_AF] ##1 (irq_q || !enb2_q[usb_regbank_pkg::S2_RX_AF]);
   endproperty
   a_almost_full: assert property (p_almost_full) else $error("almost full missed");

   property p_rx_idx_wrap;
      rx_port_rd |=> rx_idx_q == $past(rx_idx_q) + 3'h1;
   endproperty
   a_rx_idx_wrap: assert property (p_rx_idx_wrap) else $error("rx index wrong");

   property p_count_range;
      rx_count <= 7'h40 && tx_count <= 7'h40;
   endproperty
   a_count_range: assert property (p_count_range) else $error("count above 64");

   property p_flush;
      rx_flush |=> rx_count == 7'h00 ##1 !rx_out_valid || $past(rx_push);
   endproperty
   a_flush: assert property (p_flush) else $error("flush failed");

   property p_validation_block;
      validation_mode_i && !tx_valid_q && sie_tx_rd_i && !tx_data_wr |=> $stable(tx_count);
   endproperty
   a_validation_block: assert property (p_validation_block)
      else $error("gated read popped");

   property p_irq;
      (|(stat2_q & enb2_q)) |=> local_irq_o;
   endproperty
   a_irq: assert property (p_irq) else $error("irq missing");

   c_rx_full: cover property (rx_push ##1 !rx_in_ready);
   c_tx_validated: cover property (validation_mode_i && tx_valid_q && tx_pop);
   c_flush_tx: cover property (tx_flush && tx_out_valid);
   c_eot: cover property (eot_hit ##[1:4] local_irq_o);
endmodule
`default_nettype wire

// *** testbench/lbus_host_model.sv ***
`default_nettype none
module lbus_host_model (
   input wire logic core_clk_i,
   input wire logic [7:0] ldout_i,
   input wire logic ldout_oe_n_i,
   output usb_regbank_pkg::lbus_t lbus_o
);
   timeunit 1ns;
   timeprecision 1ps;
   logic oe_seen = 1'b1;
   initial lbus_o = {5'h1f, 13'h005a};
   // Strobe held over two edges; one take per assertion, one-cycle gap after
   task automatic acc(input logic w, input logic [4:0] a, input logic [7:0] d,
                      output logic [7:0] q);
      @(negedge core_clk_i);
      lbus_o.cs_n = 1'b0;
      lbus_o.addr = a;
      lbus_o.data = d;
      lbus_o.rd_n = w;
      lbus_o.wr_n = !w;
      repeat (2) @(negedge core_clk_i);
      q = ldout_i;
      oe_seen = ldout_oe_n_i;
      lbus_o.cs_n = 1'b1;
      lbus_o.rd_n = 1'b1;
      lbus_o.wr_n = 1'b1;
      // Released data must not look like the last value
      lbus_o.data = ~d;
   endtask
   // DMA cycle: acknowledge replaces chip select and address
   task automatic dma(input logic w, input logic e, input logic [7:0] d,
                      output logic [7:0] q);
      @(negedge core_clk_i);
      lbus_o.dma_acknowledge_n_n = 1'b0;
      lbus_o.eot_n = !e;
      lbus_o.data = d;
      lbus_o.rd_n = w;
      lbus_o.wr_n = !w;
      repeat (2) @(negedge core_clk_i);
      q = ldout_i;
      lbus_o.dma_acknowledge_n_n = 1'b1;
      lbus_o.eot_n = 1'b1;
      lbus_o.rd_n = 1'b1;
      lbus_o.wr_n = 1'b1;
      lbus_o.data = ~d;
   endtask
endmodule
`default_nettype wire

// *** testbench/usb_function_local_register_bank_tb.sv ***
`default_nettype none
module usb_function_local_register_bank_tb;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk = 1'b0;
   logic rst_n, irq, vmode, rxv, txr, txv, rxr, oe;
   logic [7:0] dout, en1, rxd, txd, q, poll, pksz;
   logic [5:0] af, ae;
   logic [63:0] mbox;
   usb_regbank_pkg::lbus_t lb;
   usb_regbank_pkg::sie_event_t ev;
   usb_regbank_pkg::mbox_wr_t mw;
   int fails = 0;
   int comparisons = 0;
   logic [12:0] tab [8] = '{13'h0eff, 13'h1308, 13'h1201, 13'h1601,
                            13'h0200, 13'h0300, 13'h1100, 13'h0500};
   initial forever #4 clk = ~clk;
   lbus_host_model u_lbus_host_model (.core_clk_i(clk), .ldout_i(dout), .ldout_oe_n_i(oe),
                                      .lbus_o(lb));
   usb_function_local_register_bank u_usb_function_local_register_bank (
      .core_clk_i(clk), .rst_n_i(rst_n), .lbus_i(lb), .ldout_o(dout),
      .ldout_oe_n_o(oe), .local_irq_o(irq), .interrupt_enable_first_i(en1),
      .validation_mode_i(vmode), .almost_full_threshold_i(af),
      .almost_empty_threshold_i(ae), .sie_event_i(ev), .sie_mbox_wr_i(mw),
      .ep2_mailbox_o(mbox), .poll_interval_o(poll), .packet_limit_o(pksz),
      .sie_rx_valid_i(rxv), .sie_rx_data_i(rxd), .sie_rx_ready_o(rxr),
      .sie_tx_rd_i(txr), .sie_tx_data_o(txd), .sie_tx_valid_o(txv));
   task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
      comparisons++;
      if (g !== e) begin
         fails++;
         $display("MISMATCH %s expected %h seen %h", n, e, g);
      end
   endtask
   task automatic rd(input logic [4:0] a, input logic [7:0] e);
      u_lbus_host_model.acc(1'b0, a, 8'h00, q);
      chk($sformatf("reg %h", a), e, q);
      chk("read enable", 8'h00, {7'h0, u_lbus_host_model.oe_seen});
   endtask
   task automatic wr(input logic [4:0] a, input logic [7:0] d);
      u_lbus_host_model.acc(1'b1, a, d, q);
   endtask
   task automatic pop(input logic [7:0] e);
      int n;
      n = 0;
      @(negedge clk);
      txr = 1'b1;
      @(negedge clk);
      txr = 1'b0;
      while (txv !== 1'b1 && n < 3) begin
         @(negedge clk);
         n++;
      end
      chk("tx byte", e, txv === 1'b1 ? txd : 8'hxx);
   endtask
   task automatic stop_test();
      $display("comparisons %0d fails %0d", comparisons, fails);
      if (fails == 0 && comparisons > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask
   initial begin
      repeat (20000) @(posedge clk);
      fails++;
      stop_test();
   end
   initial begin
      {rst_n, vmode, rxv, txr, rxd, ev, mw} = '0;
      {en1, af, ae} = {8'hff, 6'h3c, 6'h04};
      repeat (16) @(negedge clk);
      rst_n = 1'b1;
      foreach (tab[i]) rd(tab[i][12:8], tab[i][7:0]);
      chk("poll out", 8'hff, poll);
      chk("pksz out", 8'h08, pksz);
      wr(5'h0e, 8'h0a);
      wr(5'h13, 8'h10);
      wr(5'h11, 8'h55);
      rd(5'h0e, 8'h0a);
      rd(5'h13, 8'h10);
      rd(5'h11, 8'h00);
      chk("poll out", 8'h0a, poll);
      chk("pksz out", 8'h10, pksz);
      @(negedge clk);
      chk("idle enable", 8'h01, {7'h0, oe});
      $display("test reset done");
      @(negedge clk);
      ev = 6'h3f;
      @(negedge clk);
      ev = 6'h00;
      rd(5'h02, 8'hde);
      chk("irq", 8'h01, {7'h0, irq});
      wr(5'h02, 8'h00);
      rd(5'h02, 8'hde);
      wr(5'h02, 8'hfe);
      rd(5'h02, 8'h00);
      chk("irq", 8'h00, {7'h0, irq});
      wr(5'h03, 8'hff);
      rd(5'h03, 8'h03);
      $display("test status done");
      for (int i = 0; i < 8; i++) begin
         @(negedge clk);
         mw = {1'b1, 3'(i), 8'ha0 + 8'(i)};
      end
      @(negedge clk);
      mw = '0;
      wr(5'h08, 8'h07);
      rd(5'h09, 8'ha7);
      rd(5'h09, 8'ha0);
      wr(5'h09, 8'h55);
      rd(5'h09, 8'ha1);
      wr(5'h0c, 8'h06);
      for (int i = 1; i < 4; i++) wr(5'h0d, 8'(i * 17));
      chk("mbox 0", 8'h33, mbox[7:0]);
      chk("mbox 6", 8'h11, mbox[55:48]);
      chk("mbox 7", 8'h22, mbox[63:56]);
      rd(5'h0c, 8'h01);
      wr(5'h0c, 8'h07);
      rd(5'h0d, 8'h22);
      rd(5'h0c, 8'h00);
      $display("test mailbox done");
      for (int i = 0; i < 61; i++) begin
         @(negedge clk);
         {rxv, rxd} = {1'b1, 8'(i)};
      end
      @(negedge clk);
      rxv = 1'b0;
      rd(5'h04, 8'h01);
      rd(5'h02, 8'h01);
      chk("irq", 8'h01, {7'h0, irq});
      rd(5'h11, 8'h3d);
      rd(5'h10, 8'h00);
      rd(5'h10, 8'h01);
      wr(5'h12, 8'h10);
      rd(5'h11, 8'h00);
      rd(5'h10, 8'h00);
      rd(5'h12, 8'h05);
      wr(5'h12, 8'h04);
      rd(5'h12, 8'h01);
      wr(5'h04, 8'h01);
      rd(5'h04, 8'h00);
      for (int i = 0; i < 65; i++) begin
         @(negedge clk);
         {rxv, rxd} = {1'b1, 8'(i)};
      end
      @(negedge clk);
      rxv = 1'b0;
      chk("rx ready", 8'h00, {7'h0, rxr});
      rd(5'h11, 8'h40);
      rd(5'h12, 8'h0a);
      wr(5'h12, 8'h18);
      rd(5'h12, 8'h01);
      chk("rx ready", 8'h01, {7'h0, rxr});
      @(negedge clk);
      {rxv, rxd} = {1'b1, 8'h5c};
      @(negedge clk);
      rxv = 1'b0;
      u_lbus_host_model.dma(1'b0, 1'b1, 8'h00, q);
      chk("dma byte", 8'h5c, q);
      rd(5'h02, 8'h21);
      wr(5'h02, 8'h20);
      rd(5'h02, 8'h01);
      $display("test receive done");
      for (int i = 0; i < 5; i++) wr(5'h14, 8'h40 + 8'(i));
      rd(5'h15, 8'h05);
      pop(8'h40);
      pop(8'h41);
      rd(5'h04, 8'h03);
      vmode = 1'b1;
      @(negedge clk);
      txr = 1'b1;
      @(negedge clk);
      txr = 1'b0;
      rd(5'h15, 8'h03);
      wr(5'h16, 8'h20);
      pop(8'h42);
      rd(5'h16, 8'h00);
      vmode = 1'b0;
      u_lbus_host_model.dma(1'b1, 1'b0, 8'h45, q);
      rd(5'h15, 8'h03);
      pop(8'h43);
      pop(8'h44);
      pop(8'h45);
      @(negedge clk);
      txr = 1'b1;
      @(negedge clk);
      txr = 1'b0;
      rd(5'h16, 8'h05);
      wr(5'h16, 8'h04);
      for (int i = 0; i < 65; i++) wr(5'h14, 8'(i));
      rd(5'h15, 8'h40);
      rd(5'h16, 8'h0a);
      wr(5'h16, 8'h18);
      rd(5'h16, 8'h01);
      $display("test transmit done");
      stop_test();
   end
endmodule
`default_nettype wire
